// >>> rtl/ddi_defines.svh
`ifndef DDI_DEFINES_SVH
`define DDI_DEFINES_SVH
// ****************************************
// Widths of the command and address pins
// ****************************************
`define DDI_ADDR_W 14
`define DDI_BA_W 3
`define DDI_NBANK 8
`define DDI_AP_BIT 10
`define DDI_ROW_MSB_X16 12
`define DDI_ROW_MSB_X8 13
// ****************************************
// Layout of the crossing event word
// ****************************************
`define DDI_KIND_W 3
`define DDI_EV_W 20
`define DDI_EV_KIND_LSB 17
`define DDI_EV_BA_LSB 14
// ****************************************
// Reset values
// ****************************************
`define DDI_RST_ROW 14'h0000
`define DDI_RST_MR 14'h0000
`define DDI_RST_BANKS 8'h00
`endif

// >>> rtl/ddi_pkg.sv
package ddi_pkg;
  // Command code from row strobe, column strobe and write enable
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } ddi_cmd_t;
  // Events carried from the link into the core domain
  typedef enum logic [2:0] {
    EV_ACT = 3'h0,
    EV_RD = 3'h1,
    EV_WR = 3'h2,
    EV_PRE = 3'h3,
    EV_LMR = 3'h4,
    EV_PDE = 3'h5,
    EV_SRE = 3'h6,
    EV_PDX = 3'h7
  } ddi_ev_t;
  // Power state, one-hot
  typedef enum logic [3:0] {
    PWR_ON = 4'h1,
    PWR_PPD = 4'h2,
    PWR_APD = 4'h4,
    PWR_SREF = 4'h8
  } ddi_pwr_t;
endpackage

// >>> rtl/ddi_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ddi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  // ****************************************
  // Two-stage level synchroniser
  // ****************************************
  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ddi_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "ddi_defines.svh"
module ddi_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [`DDI_BA_W-1:0] wr_addr,
  input wire logic [`DDI_ADDR_W-1:0] wr_data,
  input wire logic [`DDI_BA_W-1:0] rd_addr,
  output logic [`DDI_ADDR_W-1:0] rd_data
);
  logic [`DDI_ADDR_W-1:0] row_mem [`DDI_NBANK];
  // ****************************************
  // Open-row store, one word per bank
  // ****************************************
  // Write port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      row_mem[wr_addr] <= wr_data;
    end
  end
  // Registered read port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= `DDI_RST_ROW;
    end else begin
      rd_data <= row_mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ddi_cmd_decode.sv
// Functional notes
// - Activate takes row address; x16 drops A13
// - Read/write take column; A10 is auto-precharge
// - Precharge: A10 low one bank, high all
// - Load mode takes op-code from address
// - Bank lines pick the target bank
// - Load mode bank lines pick mode register
// - Inputs registered on rising link clock
// - Output timing referenced to link clock
// - Registered clock enable gates internal clocking
// - Enable low: precharge/self refresh, or active
// - Power-down entry/exit and self refresh entry sampled synchronously
// - Self refresh exit seen without link clock
// - Power-down keeps only clock and enable
// - Self refresh keeps only clock enable
// - Chip select high masks every command
// - Chip select picks this rank
// - Command from strobes with chip select
`timescale 1ns/1ns
`default_nettype none
`include "ddi_defines.svh"
module ddi_cmd_decode
  import ddi_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ddr_ck,
  input wire logic ddr_cke,
  input wire logic ddr_cs_n,
  input wire logic ddr_ras_n,
  input wire logic ddr_cas_n,
  input wire logic ddr_we_n,
  input wire logic [`DDI_BA_W-1:0] ddr_ba,
  input wire logic [`DDI_ADDR_W-1:0] ddr_addr,
  input wire logic cfg_x16,
  input wire logic [`DDI_BA_W-1:0] rd_bank,
  output logic [`DDI_ADDR_W-1:0] rd_row,
  output logic out_launch_en,
  output logic cmd_valid,
  output logic [`DDI_KIND_W-1:0] cmd_kind,
  output logic [`DDI_BA_W-1:0] cmd_bank,
  output logic [`DDI_ADDR_W-1:0] cmd_addr,
  output logic cmd_auto_pre,
  output logic cmd_pre_all,
  output logic [`DDI_NBANK-1:0] bank_open,
  output logic [`DDI_ADDR_W-1:0] mr_base,
  output logic [`DDI_ADDR_W-1:0] mr_ext1,
  output logic [`DDI_ADDR_W-1:0] mr_ext2,
  output logic [`DDI_ADDR_W-1:0] mr_ext3,
  output logic [3:0] pwr_state,
  output logic core_clk_en,
  output logic ev_lost
);
  // ****************************************
  // Link domain
  // ****************************************
  logic ck_rst_n;
  logic cke_reg;
  logic cke_prev_reg;
  logic cs_n_reg;
  ddi_cmd_t cmd_reg;
  logic [`DDI_BA_W-1:0] ba_reg;
  logic [`DDI_ADDR_W-1:0] addr_reg;
  logic [`DDI_EV_W-1:0] ev_word_reg;
  logic req_tgl_reg;
  logic lost_reg;
  logic clk_on_reg;
  logic launch_reg;
  logic [2:0] ck_sync;
  logic sr_ck;
  logic pd_ck;
  logic ack_ck;
  logic busy;
  logic dec_en;
  logic ev_fire;
  ddi_ev_t ev_kind;
  logic ack_tgl_reg;
  // Core reset carried onto the link clock
  ddi_sync #(.WIDTH(1)) u_rst_sync (.clk(ddr_ck), .rst_n(1'b1), .d(reset_n), .q(ck_rst_n));
  // Power state and ack toggle into the link domain
  ddi_sync #(.WIDTH(3)) u_ck_sync (
    .clk(ddr_ck),
    .rst_n(ck_rst_n),
    .d({pwr_state == PWR_SREF, pwr_state == PWR_PPD || pwr_state == PWR_APD, ack_tgl_reg}),
    .q(ck_sync)
  );
  assign sr_ck = ck_sync[2];
  assign pd_ck = ck_sync[1];
  assign ack_ck = ck_sync[0];
  // Pin capture on the rising crossing, receivers gated in low power
  always_ff @(posedge ddr_ck) begin
    if (!ck_rst_n) begin
      cke_reg <= 1'b0;
      cke_prev_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      cmd_reg <= CMD_NOP;
      ba_reg <= '0;
      addr_reg <= '0;
    end else begin
      cke_reg <= ddr_cke;
      cke_prev_reg <= cke_reg;
      if (sr_ck || pd_ck) begin
        cs_n_reg <= 1'b1;
        cmd_reg <= CMD_NOP;
      end else begin
        cs_n_reg <= ddr_cs_n;
        cmd_reg <= ddi_cmd_t'({ddr_ras_n, ddr_cas_n, ddr_we_n});
        ba_reg <= ddr_ba;
        addr_reg <= ddr_addr;
      end
    end
  end
  // Decoder enabled by select and steady clock enable
  assign dec_en = !cs_n_reg && cke_prev_reg && cke_reg && !pd_ck && !sr_ck;
  // Event decode
  always_comb begin
    ev_fire = 1'b0;
    ev_kind = EV_PDE;
    if (cke_prev_reg && !cke_reg) begin
      ev_fire = 1'b1;
      ev_kind = (!cs_n_reg && cmd_reg == CMD_REF) ? EV_SRE : EV_PDE;
    end else if (!cke_prev_reg && cke_reg && !sr_ck) begin
      ev_fire = 1'b1;
      ev_kind = EV_PDX;
    end else if (dec_en) begin
      ev_fire = 1'b1;
      case (cmd_reg)
        CMD_ACT: ev_kind = EV_ACT;
        CMD_RD: ev_kind = EV_RD;
        CMD_WR: ev_kind = EV_WR;
        CMD_PRE: ev_kind = EV_PRE;
        CMD_LMR: ev_kind = EV_LMR;
        default: ev_fire = 1'b0; // Refresh, burst stop and no-op stay local
      endcase
    end
  end
  // Handshake sender, word held until acknowledged
  assign busy = req_tgl_reg != ack_ck;
  always_ff @(posedge ddr_ck) begin
    if (!ck_rst_n) begin
      ev_word_reg <= '0;
      req_tgl_reg <= 1'b0;
    end else if (ev_fire && !busy) begin
      ev_word_reg <= {ev_kind, ba_reg, addr_reg};
      req_tgl_reg <= !req_tgl_reg;
    end
  end
  // Sticky flag for an event met by a busy crossing
  always_ff @(posedge ddr_ck) begin
    if (!ck_rst_n) begin
      lost_reg <= 1'b0;
    end else if (ev_fire && busy) begin
      lost_reg <= 1'b1;
    end
  end
  // Clocking gate and output launch reference
  always_ff @(posedge ddr_ck) begin
    if (!ck_rst_n) begin
      clk_on_reg <= 1'b0;
      launch_reg <= 1'b0;
    end else begin
      clk_on_reg <= cke_reg;
      launch_reg <= cke_reg && !pd_ck && !sr_ck;
    end
  end
  assign out_launch_en = launch_reg;
  // ****************************************
  // Core domain
  // ****************************************
  logic [4:0] m_sync;
  logic x16_m;
  logic cke_m;
  logic req_m;
  logic req_seen_reg;
  logic new_ev;
  ddi_ev_t ev_kind_m;
  logic [`DDI_BA_W-1:0] ev_ba_m;
  logic [`DDI_ADDR_W-1:0] ev_addr_m;
  logic [`DDI_NBANK-1:0] bank_bit;
  logic [`DDI_ADDR_W-1:0] row_masked;
  logic [`DDI_NBANK-1:0] bank_open_reg;
  ddi_pwr_t pwr_reg;
  ddi_pwr_t pwr_next;
  // Pins and link levels into the core domain
  ddi_sync #(.WIDTH(5)) u_m_sync (
    .clk(mclk),
    .rst_n(reset_n),
    .d({cfg_x16, ddr_cke, lost_reg, clk_on_reg, req_tgl_reg}),
    .q(m_sync)
  );
  assign x16_m = m_sync[4];
  assign cke_m = m_sync[3];
  assign ev_lost = m_sync[2];
  assign core_clk_en = m_sync[1];
  assign req_m = m_sync[0];
  // Handshake receiver
  assign new_ev = req_m != req_seen_reg;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      req_seen_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
    end else begin
      req_seen_reg <= req_m;
      ack_tgl_reg <= req_seen_reg;
    end
  end
  // Fields of the held event word
  assign ev_kind_m = ddi_ev_t'(ev_word_reg[`DDI_EV_W-1:`DDI_EV_KIND_LSB]);
  assign ev_ba_m = ev_word_reg[`DDI_EV_KIND_LSB-1:`DDI_EV_BA_LSB];
  assign ev_addr_m = ev_word_reg[`DDI_ADDR_W-1:0];
  assign bank_bit = 8'h01 << ev_ba_m;
  // Row address width by organisation
  assign row_masked = x16_m ? {1'b0, ev_addr_m[`DDI_ROW_MSB_X16:0]} :
    ev_addr_m[`DDI_ROW_MSB_X8:0];
  // Open-row store
  ddi_mem u_rows (
    .clk(mclk),
    .rst_n(reset_n),
    .wr_en(new_ev && ev_kind_m == EV_ACT),
    .wr_addr(ev_ba_m),
    .wr_data(row_masked),
    .rd_addr(rd_bank),
    .rd_data(rd_row)
  );
  // Bank open state
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bank_open_reg <= `DDI_RST_BANKS;
    end else if (new_ev) begin
      case (ev_kind_m)
        EV_ACT: bank_open_reg <= bank_open_reg | bank_bit;
        EV_PRE: begin
          if (ev_addr_m[`DDI_AP_BIT]) begin
            bank_open_reg <= `DDI_RST_BANKS;
          end else begin
            bank_open_reg <= bank_open_reg & ~bank_bit;
          end
        end
        EV_RD, EV_WR: begin
          if (ev_addr_m[`DDI_AP_BIT]) begin
            bank_open_reg <= bank_open_reg & ~bank_bit;
          end
        end
        default: bank_open_reg <= bank_open_reg;
      endcase
    end
  end
  assign bank_open = bank_open_reg;
  // Mode registers loaded by bank select
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mr_base <= `DDI_RST_MR;
      mr_ext1 <= `DDI_RST_MR;
      mr_ext2 <= `DDI_RST_MR;
      mr_ext3 <= `DDI_RST_MR;
    end else if (new_ev && ev_kind_m == EV_LMR) begin
      case (ev_ba_m[1:0])
        2'h0: mr_base <= ev_addr_m;
        2'h1: mr_ext1 <= ev_addr_m;
        2'h2: mr_ext2 <= ev_addr_m;
        default: mr_ext3 <= ev_addr_m;
      endcase
    end
  end
  // Command report to the core
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmd_valid <= 1'b0;
      cmd_kind <= '0;
      cmd_bank <= '0;
      cmd_addr <= '0;
      cmd_auto_pre <= 1'b0;
      cmd_pre_all <= 1'b0;
    end else begin
      cmd_valid <= new_ev;
      if (new_ev) begin
        cmd_kind <= ev_kind_m;
        cmd_bank <= ev_ba_m;
        cmd_addr <= (ev_kind_m == EV_ACT) ? row_masked : ev_addr_m;
        cmd_auto_pre <= (ev_kind_m == EV_RD || ev_kind_m == EV_WR) &&
          ev_addr_m[`DDI_AP_BIT];
        cmd_pre_all <= ev_kind_m == EV_PRE && ev_addr_m[`DDI_AP_BIT];
      end
    end
  end
  // Power state next value
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PWR_ON: begin
        if (new_ev && (ev_kind_m == EV_PDE || ev_kind_m == EV_SRE)) begin
          if (|bank_open_reg) begin
            pwr_next = PWR_APD;
          end else if (ev_kind_m == EV_SRE) begin
            pwr_next = PWR_SREF;
          end else begin
            pwr_next = PWR_PPD;
          end
        end
      end
      PWR_PPD, PWR_APD: begin
        if (new_ev && ev_kind_m == EV_PDX) begin
          pwr_next = PWR_ON;
        end
      end
      PWR_SREF: begin
        if (cke_m) begin
          pwr_next = PWR_ON;
        end
      end
      default: pwr_next = PWR_ON;
    endcase
  end
  // Power state register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pwr_reg <= PWR_ON;
    end else begin
      pwr_reg <= pwr_next;
    end
  end
  assign pwr_state = pwr_reg;
  // ****************************************
  // Checks
  // ****************************************
  chk_deselect_quiet: assert property (@(posedge ddr_ck) disable iff (!ck_rst_n)
    (cs_n_reg && cke_prev_reg && cke_reg) |-> !ev_fire)
    else $error("event raised in a deselect cycle");
  chk_lowpower_mask: assert property (@(posedge ddr_ck) disable iff (!ck_rst_n)
    (pd_ck && cke_prev_reg && cke_reg) |-> !ev_fire)
    else $error("command taken during power-down");
  chk_clk_gate: assert property (@(posedge ddr_ck) disable iff (!ck_rst_n)
    ddr_cke ##1 ddr_cke |=> clk_on_reg)
    else $error("clocking not enabled after clock enable high");
  chk_word_hold: assert property (@(posedge ddr_ck) disable iff (!ck_rst_n)
    busy |=> $stable(ev_word_reg) || !$past(busy))
    else $error("event word changed while crossing busy");
  chk_act_opens: assert property (@(posedge mclk) disable iff (!reset_n)
    (new_ev && ev_kind_m == EV_ACT) |=> (bank_open_reg == ($past(bank_open_reg) | $past(bank_bit))))
    else $error("activate did not open its bank");
  chk_pre_all: assert property (@(posedge mclk) disable iff (!reset_n)
    (new_ev && ev_kind_m == EV_PRE && ev_addr_m[`DDI_AP_BIT]) |=> bank_open_reg == 8'h00 && cmd_pre_all)
    else $error("precharge all left a bank open");
  chk_pre_one: assert property (@(posedge mclk) disable iff (!reset_n)
    (new_ev && ev_kind_m == EV_PRE && !ev_addr_m[`DDI_AP_BIT]) |=>
    (bank_open_reg == ($past(bank_open_reg) & ~$past(bank_bit))))
    else $error("single precharge touched other banks");
  chk_mode_load: assert property (@(posedge mclk) disable iff (!reset_n)
    (new_ev && ev_kind_m == EV_LMR && ev_ba_m[1:0] == 2'h1) |=> mr_ext1 == $past(ev_addr_m))
    else $error("extended mode register 1 not loaded");
  chk_auto_pre: assert property (@(posedge mclk) disable iff (!reset_n)
    (new_ev && ev_kind_m == EV_RD) |=> cmd_valid && cmd_auto_pre == $past(ev_addr_m[`DDI_AP_BIT]))
    else $error("read auto-precharge flag lost");
  chk_active_pd: assert property (@(posedge mclk) disable iff (!reset_n)
    (pwr_reg == PWR_ON && new_ev && ev_kind_m == EV_SRE && |bank_open_reg) |=> pwr_reg == PWR_APD)
    else $error("open bank did not give active power-down");
  chk_sr_exit: assert property (@(posedge mclk) disable iff (!reset_n)
    (pwr_reg == PWR_SREF && cke_m) |=> pwr_reg == PWR_ON)
    else $error("self refresh not left on clock enable");
endmodule
`default_nettype wire

// >>> verif/ddi_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module ddi_ctrl_model (
  output logic ddr_ck,
  output logic ddr_cke,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output logic [2:0] ddr_ba,
  output logic [13:0] ddr_addr
);
  logic ck_run;
  // ****************************************
  // Link clock, parked low while stopped
  // ****************************************
  initial begin
    ck_run = 1'b1;
    ddr_ck = 1'b0;
    forever begin
      #7 ddr_ck = ck_run;
      #8 ddr_ck = 1'b0;
    end
  end
  // Pins at power-up: enable low, deselected
  initial begin
    ddr_cke = 1'b0;
    ddr_cs_n = 1'b1;
    {ddr_ras_n, ddr_cas_n, ddr_we_n} = 3'h7;
    ddr_ba = 3'h0;
    ddr_addr = 14'h0000;
  end
  // One command cycle after the rising crossing, then spacing
  task automatic cycle(input logic cs_n, input logic [2:0] code, input logic [2:0] ba,
                       input logic [13:0] a, input logic cke);
    @(posedge ddr_ck);
    #1;
    ddr_cs_n = cs_n;
    {ddr_ras_n, ddr_cas_n, ddr_we_n} = code;
    ddr_ba = ba;
    ddr_addr = a;
    ddr_cke = cke;
    @(posedge ddr_ck);
    #1;
    ddr_cs_n = 1'b1;
    {ddr_ras_n, ddr_cas_n, ddr_we_n} = 3'h7;
    ddr_ba = ~ba; // Released lines show the inverse
    ddr_addr = ~a;
    repeat (25) @(posedge ddr_ck);
  endtask
  // Stop the clock, then raise enable with no clock
  task automatic sr_exit();
    ck_run = 1'b0;
    #200;
    ddr_cke = 1'b1;
  endtask
  // Restart the clock and let the link settle
  task automatic restart();
    ck_run = 1'b1;
    repeat (25) @(posedge ddr_ck);
  endtask
endmodule
`default_nettype wire

// >>> verif/ddr2_cmd_addr_input_decode_test.sv
`timescale 1ns/1ns
`default_nettype none
module ddr2_cmd_addr_input_decode_test
  import ddi_pkg::*;
;
  logic mclk, reset_n, cfg_x16, cmd_valid, cmd_auto_pre, cmd_pre_all, core_clk_en, ev_lost;
  logic ddr_ck, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, out_launch_en;
  logic [2:0] ddr_ba, rd_bank, cmd_kind, cmd_bank;
  logic [13:0] ddr_addr, rd_row, cmd_addr, mr_base, mr_ext1, mr_ext2, mr_ext3;
  logic [7:0] bank_open;
  logic [3:0] pwr_state;
  int bad_count, cmp_count, n;
  logic [13:0] m_row [8];
  logic [13:0] m_mr [4];
  logic [7:0] m_open;
  logic [3:0] m_pwr;
  logic [2:0] b;
  ddi_ctrl_model ctl (.ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n),
    .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba),
    .ddr_addr(ddr_addr));
  ddi_cmd_decode dut (.mclk(mclk), .reset_n(reset_n), .ddr_ck(ddr_ck), .ddr_cke(ddr_cke),
    .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n),
    .ddr_ba(ddr_ba), .ddr_addr(ddr_addr), .cfg_x16(cfg_x16), .rd_bank(rd_bank),
    .rd_row(rd_row), .out_launch_en(out_launch_en), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .cmd_auto_pre(cmd_auto_pre), .cmd_pre_all(cmd_pre_all), .bank_open(bank_open),
    .mr_base(mr_base), .mr_ext1(mr_ext1), .mr_ext2(mr_ext2), .mr_ext3(mr_ext3),
    .pwr_state(pwr_state), .core_clk_en(core_clk_en), .ev_lost(ev_lost));
  // ****************************************
  // Core clock
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Verdict and end of run
  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait for an event, bounded, and compare its fields
  task automatic ev(input logic [2:0] k, input logic [2:0] eb, input logic [13:0] a,
                    input logic ap, input logic pa, input logic full);
    n = 0;
    while (cmd_valid !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      $display("mismatch %0t no event", $time);
      report_and_stop();
    end
    chk(cmd_kind, k);
    if (full) begin
      chk(cmd_bank, eb);
      chk(cmd_addr, a);
      chk(cmd_auto_pre, ap);
      chk(cmd_pre_all, pa);
    end
  endtask
  // Expect no event for a while
  task automatic quiet();
    repeat (40) begin
      @(posedge mclk);
      #1;
      if (cmd_valid !== 1'b0) chk(cmd_valid, 1'b0);
    end
    chk(cmd_valid, 1'b0);
  endtask
  // Compare held state with the model, then read back one row
  task automatic state(input logic [2:0] sb);
    @(posedge mclk);
    #1;
    chk(bank_open, m_open);
    chk(pwr_state, m_pwr);
    chk(mr_base, m_mr[0]);
    chk(mr_ext1, m_mr[1]);
    chk(mr_ext2, m_mr[2]);
    chk(mr_ext3, m_mr[3]);
    rd_bank = sb;
    @(posedge mclk);
    #1;
    if (m_open[sb]) chk(rd_row, m_row[sb]);
  endtask
  // Issue a bank command and update the model
  task automatic go(input logic [2:0] code, input logic [2:0] gb, input logic [13:0] a);
    logic [2:0] k;
    logic [13:0] ea;
    logic ap, pa;
    ea = a;
    ap = 1'b0;
    pa = 1'b0;
    k = EV_LMR;
    case (code)
      CMD_ACT: begin
        k = EV_ACT;
        if (cfg_x16) ea[13] = 1'b0;
        m_open[gb] = 1'b1;
        m_row[gb] = ea;
      end
      CMD_RD, CMD_WR: begin
        k = (code == CMD_RD) ? EV_RD : EV_WR;
        ap = a[10];
        if (ap) m_open[gb] = 1'b0;
      end
      CMD_PRE: begin
        k = EV_PRE;
        pa = a[10];
        if (pa) m_open = 8'h00;
        else m_open[gb] = 1'b0;
      end
      default: m_mr[gb[1:0]] = a;
    endcase
    fork
      ctl.cycle(1'b0, code, gb, a, 1'b1);
      ev(k, gb, ea, ap, pa, 1'b1);
    join
    state(gb);
  endtask
  // Clock enable transition with its expected power state
  task automatic pw(input logic cs_n, input logic [2:0] code, input logic cke,
                    input logic [2:0] k, input logic [3:0] p);
    fork
      ctl.cycle(cs_n, code, 3'h0, 14'h0000, cke);
      ev(k, 3'h0, 14'h0000, 1'b0, 1'b0, 1'b0);
    join
    m_pwr = p;
    state(3'h0);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n = $urandom(4062);
    reset_n = 1'b0;
    cfg_x16 = 1'b0;
    rd_bank = 3'h0;
    bad_count = 0;
    cmp_count = 0;
    m_open = 8'h00;
    m_pwr = PWR_ON;
    for (int i = 0; i < 4; i++) m_mr[i] = 14'h0000;
    repeat (2) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    state(3'h0);
    ctl.cycle(1'b1, CMD_NOP, 3'h0, 14'h0000, 1'b1);
    for (int x = 0; x < 2; x++) begin
      cfg_x16 = x[0];
      repeat (4) @(posedge mclk);
      #1;
      b = 3'($urandom);
      go(CMD_ACT, b, 14'($urandom) | 14'h2000);
      go(CMD_RD, b, 14'($urandom) & 14'h3BFF);
      go(CMD_WR, b, 14'($urandom) | 14'h0400);
    end
    for (int i = 0; i < 4; i++) begin
      go(CMD_LMR, {1'($urandom), 2'(i)}, 14'($urandom));
    end
    go(CMD_ACT, 3'h1, 14'($urandom));
    go(CMD_ACT, 3'h5, 14'($urandom));
    go(CMD_PRE, 3'h1, 14'h0000);
    fork
      ctl.cycle(1'b1, CMD_PRE, 3'h5, 14'h0400, 1'b1);
      quiet();
    join
    state(3'h5);
    go(CMD_PRE, 3'h0, 14'h0400);
    pw(1'b1, CMD_NOP, 1'b0, EV_PDE, PWR_PPD);
    chk(core_clk_en, 1'b0);
    fork
      ctl.cycle(1'b0, CMD_ACT, 3'h3, 14'h0123, 1'b0);
      quiet();
    join
    pw(1'b1, CMD_NOP, 1'b1, EV_PDX, PWR_ON);
    chk(core_clk_en, 1'b1);
    go(CMD_ACT, 3'h2, 14'($urandom));
    pw(1'b1, CMD_NOP, 1'b0, EV_PDE, PWR_APD);
    pw(1'b1, CMD_NOP, 1'b1, EV_PDX, PWR_ON);
    pw(1'b0, CMD_REF, 1'b0, EV_SRE, PWR_APD);
    pw(1'b1, CMD_NOP, 1'b1, EV_PDX, PWR_ON);
    go(CMD_PRE, 3'h2, 14'h0400);
    pw(1'b0, CMD_REF, 1'b0, EV_SRE, PWR_SREF);
    ctl.sr_exit();
    n = 0;
    while (pwr_state !== PWR_ON && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(pwr_state, PWR_ON);
    m_pwr = PWR_ON;
    ctl.restart();
    go(CMD_ACT, 3'h7, 14'($urandom));
    chk(out_launch_en, 1'b1);
    chk(ev_lost, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
